//--- bench/asram_host_tb.sv
// Self-checking testbench for the static memory host controller.
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fail_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module asram_host_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int REC = 8;
  logic                  ref_clk_i = 1'b0;
  logic                  rstn_i = 1'b0;
  asram_pkg::asram_req_t req_i = '0;
  logic                  req_valid_i = 1'b0;
  logic                  sleep_req_i = 1'b0;
  logic                  req_ready_o, rdata_valid_o, sleep_o, mem_dq_oe_o, clash;
  logic [7:0]            rdata_o, mem_dq_o, mem_dq_i;
  logic [18:0]           mem_addr_o;
  asram_pkg::asram_ctl_t mem_ctl_o;
  int                    fail_count = 0;
  int                    cmp_count = 0;
  always #20 ref_clk_i = ~ref_clk_i;
  asram_host #(.REC_CYCLES(REC)) dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .req_i(req_i),
    .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
    .sleep_req_i(sleep_req_i), .sleep_o(sleep_o), .mem_addr_o(mem_addr_o), .mem_ctl_o(mem_ctl_o),
    .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o));
  asram_mem_model mem (.addr_i(mem_addr_o), .cs_n_i(mem_ctl_o.cs_n), .we_n_i(mem_ctl_o.we_n),
    .oe_n_i(mem_ctl_o.oe_n), .dq_i(mem_dq_o), .dq_oe_i(mem_dq_oe_o), .dq_o(mem_dq_i), .clash_o(clash));
  task automatic wait_rdy(output int k);
    k = 0;
    while (req_ready_o !== 1'b1 && k < 200)
    begin
      `CHK(mem_ctl_o.cs_n, 1'b1)
      @(posedge ref_clk_i);
      #2;
      k++;
    end
    `CHK(req_ready_o, 1'b1)
  endtask : wait_rdy
  task automatic do_access(input logic wr, input logic [18:0] a, input logic [7:0] d);
    int k, n, v;
    wait_rdy(k);
    req_i = '{write: wr, addr: a, wdata: d};
    req_valid_i = 1'b1;
    @(posedge ref_clk_i);
    #2;
    req_valid_i = 1'b0;
    n = 0;
    v = 0;
    repeat (7)
    begin
      if (mem_ctl_o.cs_n === 1'b0)
      begin
        n++;
        if (wr)
          `CHK({mem_ctl_o.we_n, mem_ctl_o.oe_n, mem_dq_oe_o, mem_addr_o, mem_dq_o}, {2'b01, 1'b1, a, d})
        else
          `CHK({mem_ctl_o.we_n, mem_ctl_o.oe_n, mem_dq_oe_o, mem_addr_o}, {2'b10, 1'b0, a})
      end
      if (!wr && rdata_valid_o === 1'b1)
      begin
        v++;
        `CHK(rdata_o, d)
      end
      @(posedge ref_clk_i);
      #2;
    end
    `CHK(n, wr ? asram_pkg::WR_CYC : asram_pkg::RD_CYC)
    `CHK(v, wr ? 0 : 1)
  endtask : do_access
  task automatic t_reset;
    int k;
    `CHK({mem_ctl_o, mem_dq_oe_o, req_ready_o}, 5'h1c)
    wait_rdy(k);
    `CHK(k >= REC, 1'b1)
    $display("test reset done");
  endtask : t_reset
  task automatic t_rw;
    do_access(1'b1, 19'h00000, 8'h5a);
    do_access(1'b1, 19'h7ffff, 8'ha5);
    do_access(1'b0, 19'h00000, 8'h5a);
    do_access(1'b0, 19'h7ffff, 8'ha5);
    $display("test write read done");
  endtask : t_rw
  task automatic t_sleep;
    int k;
    sleep_req_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #2;
    `CHK({sleep_o, mem_ctl_o.cs_n}, 2'b11)
    sleep_req_i = 1'b0;
    @(posedge ref_clk_i);
    #2;
    wait_rdy(k);
    `CHK(k >= REC, 1'b1)
    do_access(1'b0, 19'h7ffff, 8'ha5);
    `CHK(clash, 1'b0)
    $display("test sleep done");
  endtask : t_sleep
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (2) @(posedge ref_clk_i);
    #2;
    rstn_i = 1'b1;
    t_reset();
    t_rw();
    t_sleep();
    close_out();
  end
  initial
  begin
    #20000;
    fail_count++;
    close_out();
  end
endmodule : asram_host_tb

//--- bench/asram_mem_model.sv
// Behavioural model of the static memory seen from the host controller pins.
module asram_mem_model #(
  parameter int ACC_NS = 100,
  parameter int OFF_NS = 30
) (
  input  wire logic [18:0] addr_i,
  input  wire logic        cs_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic [7:0]  dq_i,
  input  wire logic        dq_oe_i,
  output logic [7:0]       dq_o,
  output logic             clash_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [logic [18:0]];
  logic [7:0] lat;
  logic       armed;
  logic       drv;
  initial
  begin
    dq_o = 8'h00;
    clash_o = 1'b0;
    armed = 1'b0;
  end
  assign drv = !cs_n_i && we_n_i && !oe_n_i;
  // Store on the first trailing edge of the overlap; the bus is garbage when not driven.
  always @(cs_n_i or we_n_i or dq_i or dq_oe_i)
  begin
    if (!cs_n_i && !we_n_i)
    begin
      armed = 1'b1;
      lat = dq_oe_i ? dq_i : 8'hxx;
    end
    else if (armed)
    begin
      mem[addr_i] = lat;
      armed = 1'b0;
    end
  end
  // Valid data after the access time; a released bus shows the inverse of its last value.
  always @(addr_i or drv)
  begin
    if (drv)
      dq_o <= #(ACC_NS) (mem.exists(addr_i) ? mem[addr_i] : 8'hxx);
    else
      dq_o <= #(OFF_NS) ~dq_o;
  end
  always @(dq_oe_i or drv)
    if (dq_oe_i && drv)
      clash_o = 1'b1;
endmodule : asram_mem_model

//--- core/asram_host.sv
// Host controller that drives an asynchronous 512K x 8 static memory through its pins.
//
// Summary of operation
// RULE_01 - A write is stored only while chip select and write strobe are both low, so the host overlaps them.
// RULE_02 - Write strobe falls with or before chip select so the memory keeps its data pins floating.
// RULE_03 - The host never drives the data lines while the memory may be driving them.
// RULE_04 - A read holds address and chip select for at least the read cycle before sampling data.
// RULE_05 - Output enable is low for the whole read so data is valid when sampled.
// RULE_06 - After a read the host waits the output float time before driving the data lines.
// RULE_07 - Read data is sampled before the address changes.
// RULE_08 - Address, strobe width and write data setup are held for the write cycle before the strobe rises.
// RULE_09 - Chip select is low for at least the write cycle before the write ends.
// RULE_10 - Output enable stays high during writes so the memory never drives after the strobe rises.
// RULE_11 - Chip select is already high when the host enters retention sleep.
// RULE_12 - After power is restored chip select stays high for the recovery time before any access.
// RULE_13 - A read uses chip select low, write strobe high and output enable low.
// RULE_14 - Between accesses chip select is high and the memory is in standby.
// RULE_15 - Write data is held until both strobe and chip select have risen together.
// RULE_16 - The address is set before the cycle starts and held unchanged through it; the host loads it on the same edge that chip select falls.
module asram_host #(
  parameter int unsigned REC_CYCLES = asram_pkg::REC_CYC
) (
  input  wire logic                           ref_clk_i,
  input  wire logic                           rstn_i,
  input  wire asram_pkg::asram_req_t          req_i,
  input  wire logic                           req_valid_i,
  output logic                                req_ready_o,
  output logic [asram_pkg::DATA_W-1:0]        rdata_o,
  output logic                                rdata_valid_o,
  input  wire logic                           sleep_req_i,
  output logic                                sleep_o,
  output logic [asram_pkg::ADDR_W-1:0]        mem_addr_o,
  output asram_pkg::asram_ctl_t               mem_ctl_o,
  input  wire logic [asram_pkg::DATA_W-1:0]   mem_dq_i,
  output logic [asram_pkg::DATA_W-1:0]        mem_dq_o,
  output logic                                mem_dq_oe_o
);

  // A recovery count of zero would wrap the last count and end recovery after two cycles.
  if (REC_CYCLES < 1)
  begin : g_bad_rec
    $error("REC_CYCLES must be at least one");
  end

  localparam int unsigned CNT_W = $clog2(REC_CYCLES + 1) + 1;
  localparam logic [CNT_W-1:0] RD_LAST  = CNT_W'(asram_pkg::RD_CYC - 1);
  localparam logic [CNT_W-1:0] WR_LAST  = CNT_W'(asram_pkg::WR_CYC - 1);
  localparam logic [CNT_W-1:0] OFF_LAST = CNT_W'(asram_pkg::OFF_CYC - 1);
  localparam logic [CNT_W-1:0] REC_LAST = CNT_W'(REC_CYCLES - 1);

  asram_pkg::asram_state_t state;
  logic [CNT_W-1:0]        cnt;
  logic                    cnt_done;

  always_comb
  begin
    unique case (state)
      asram_pkg::ST_READ:    cnt_done = (cnt == RD_LAST);
      asram_pkg::ST_WRITE:   cnt_done = (cnt == WR_LAST);
      asram_pkg::ST_TURN:    cnt_done = (cnt == OFF_LAST);
      asram_pkg::ST_RECOVER: cnt_done = (cnt == REC_LAST);
      default:               cnt_done = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      state <= asram_pkg::ST_RECOVER;
      cnt   <= '0;
    end
    else
    begin
      unique case (state)
        asram_pkg::ST_RECOVER, asram_pkg::ST_TURN:
        begin
          cnt <= cnt + 1'b1;
          if (cnt_done)
          begin
            state <= asram_pkg::ST_IDLE; // [RULE_12] [RULE_06]
            cnt   <= '0;
          end
        end
        asram_pkg::ST_IDLE:
        begin
          cnt <= '0;
          if (sleep_req_i)
            state <= asram_pkg::ST_SLEEP; // [RULE_11]
          else if (req_valid_i)
            state <= req_i.write ? asram_pkg::ST_WRITE : asram_pkg::ST_READ;
        end
        asram_pkg::ST_READ:
        begin
          cnt <= cnt + 1'b1;
          if (cnt_done)
          begin
            state <= asram_pkg::ST_TURN;
            cnt   <= '0;
          end
        end
        asram_pkg::ST_WRITE:
        begin
          cnt <= cnt + 1'b1;
          if (cnt_done)
          begin
            state <= asram_pkg::ST_IDLE; // [RULE_08] [RULE_09]
            cnt   <= '0;
          end
        end
        asram_pkg::ST_SLEEP:
        begin
          cnt <= '0;
          if (!sleep_req_i)
            state <= asram_pkg::ST_RECOVER; // [RULE_12]
        end
        default:
        begin
          state <= asram_pkg::ST_RECOVER;
          cnt   <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Memory pins
  // ----------------------------------------------------------------
  // The access strobe and chip select move together: both fall on entry and both rise on exit.
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      mem_ctl_o   <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1};
      mem_dq_oe_o <= 1'b0;
      mem_dq_o    <= '0;
      mem_addr_o  <= '0;
    end
    else if (state == asram_pkg::ST_IDLE && !sleep_req_i && req_valid_i)
    begin
      mem_addr_o  <= req_i.addr; // [RULE_16]
      mem_dq_o    <= req_i.wdata;
      mem_ctl_o   <= '{cs_n: 1'b0, we_n: !req_i.write, oe_n: req_i.write}; // [RULE_01] [RULE_02] [RULE_13] [RULE_10]
      mem_dq_oe_o <= req_i.write; // [RULE_03]
    end
    else if (cnt_done && (state == asram_pkg::ST_READ || state == asram_pkg::ST_WRITE))
    begin
      mem_ctl_o <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1}; // [RULE_15] [RULE_14]
    end
    else if (state == asram_pkg::ST_IDLE)
    begin
      mem_dq_oe_o <= 1'b0; // [RULE_15]
    end
  end

  // ----------------------------------------------------------------
  // Host side
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_o       <= '0;
      rdata_valid_o <= 1'b0;
      req_ready_o   <= 1'b0;
      sleep_o       <= 1'b0;
    end
    else
    begin
      rdata_valid_o <= 1'b0;
      if (state == asram_pkg::ST_READ && cnt_done)
      begin
        rdata_o       <= mem_dq_i; // [RULE_04] [RULE_05] [RULE_07]
        rdata_valid_o <= 1'b1;
      end
      req_ready_o <= (state == asram_pkg::ST_IDLE) ? !(req_valid_i || sleep_req_i)
                   : (cnt_done && state != asram_pkg::ST_READ);
      sleep_o     <= (state == asram_pkg::ST_SLEEP) || (state == asram_pkg::ST_IDLE && sleep_req_i);
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence access_start_s;
    $fell(mem_ctl_o.cs_n);
  endsequence

  sequence wr_hold_s;
    (!mem_ctl_o.cs_n && !mem_ctl_o.we_n) [*2] ##1 (mem_ctl_o.cs_n && mem_ctl_o.we_n);
  endsequence

  sequence rd_hold_s;
    (!mem_ctl_o.cs_n && !mem_ctl_o.oe_n) [*3] ##1 rdata_valid_o;
  endsequence

  no_contend_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RULE_03]
    mem_dq_oe_o |-> mem_ctl_o.oe_n)
    else $error("host drives data while memory output enabled");
  we_with_cs_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RULE_02]
    $fell(mem_ctl_o.we_n) |-> $fell(mem_ctl_o.cs_n))
    else $error("write strobe fell without chip select");
  wr_width_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RULE_09]
    (access_start_s and !mem_ctl_o.we_n) |-> wr_hold_s)
    else $error("write cycle length wrong");
  rd_width_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RULE_04]
    (access_start_s and mem_ctl_o.we_n) |-> rd_hold_s)
    else $error("read sampled too early or late");
  addr_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RULE_16]
    (!mem_ctl_o.cs_n && !$rose(mem_ctl_o.cs_n) && !$fell(mem_ctl_o.cs_n)) |-> $stable(mem_addr_o))
    else $error("address changed during access");
  data_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RULE_15]
    $rose(mem_ctl_o.we_n) |-> mem_dq_oe_o && $stable(mem_dq_o))
    else $error("write data not held at strobe rise");
  turn_gap_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RULE_06]
    $rose(mem_ctl_o.oe_n) |-> !mem_dq_oe_o [*2])
    else $error("data driven too soon after read");
  sleep_cs_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RULE_11]
    sleep_o |-> mem_ctl_o.cs_n)
    else $error("chip select low in sleep");
  rec_cs_a: assert property (@(posedge ref_clk_i) disable iff (!rstn_i) // [RULE_12]
    (state == asram_pkg::ST_RECOVER) |-> mem_ctl_o.cs_n)
    else $error("chip select low during recovery");

endmodule : asram_host

//--- core/asram_pkg.sv
// Package with timing constants and request carriers for the static memory host controller.
package asram_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS   = 40;
  localparam int unsigned T_READ_FAST_NS  = 85;
  localparam int unsigned T_READ_SLOW_NS  = 100;
  localparam int unsigned T_WP_NS         = 60;
  localparam int unsigned T_AW_SLOW_NS    = 80;
  localparam int unsigned T_DS_NS         = 35;
  localparam int unsigned T_OFF_NS        = 35;
  localparam int unsigned T_REC_PD_MS     = 5;
  localparam int unsigned NS_PER_MS       = 1000000;

  // Least times round up to whole cycles.
  localparam int unsigned RD_CYC  = (T_READ_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WR_CYC  = (T_AW_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OFF_CYC = (T_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned REC_CYC = (T_REC_PD_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned ADDR_W = 19;
  localparam int unsigned DATA_W = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asram_req_t;

  typedef struct packed {
    logic cs_n;
    logic we_n;
    logic oe_n;
  } asram_ctl_t;

  typedef enum logic [2:0] {
    ST_RECOVER = 3'h0,
    ST_IDLE    = 3'h1,
    ST_READ    = 3'h2,
    ST_WRITE   = 3'h3,
    ST_TURN    = 3'h4,
    ST_SLEEP   = 3'h5
  } asram_state_t;

endpackage : asram_pkg
